// ===== src/pcr_pkg.sv
// Function
// RULE1 - Counter high byte holds bits 15:8, resets zero.
// RULE2 - High byte reads return snapshot from low read.
// RULE3 - Watchdog lock blocks software writes to high byte.
// RULE4 - Compare low byte holds bits 7:0, six channels.
// RULE5 - Compare high byte holds bits 15:8, resets zero.
// RULE6 - Reload select steers byte addresses to reload values.
// RULE7 - Writing compare low byte clears compare enable.
// RULE8 - Writing compare high byte sets compare enable.
// RULE9 - Compare enable high enables the channel comparator.
// RULE10 - Software writes low byte before high byte.
package pcr_pkg;
  // Number of capture/compare channels with fixed byte addresses.
  localparam int PCR_NUM_CH = 6;
  // Width of one register byte.
  localparam int PCR_BYTE_W = 8;
  // Counter low byte address; a read here loads the high byte snapshot.
  localparam logic [7:0] PCR_CNT_LO_ADDR = 8'hF9;
  // Counter high byte address.
  localparam logic [7:0] PCR_CNT_HI_ADDR = 8'hFA;
  // Compare low byte addresses, channels 0 to 5.
  localparam logic [7:0] PCR_CMP_LO_ADDR [0:5] = '{8'hFB, 8'hE9, 8'hEB, 8'hED, 8'hFD, 8'hD2};
  // Compare high byte addresses, channels 0 to 5.
  localparam logic [7:0] PCR_CMP_HI_ADDR [0:5] = '{8'hFC, 8'hEA, 8'hEC, 8'hEE, 8'hFE, 8'hD3};
  // Reset value of every data byte.
  localparam logic [7:0] PCR_BYTE_RST = 8'h00;
  // Reset value of a compare enable bit.
  localparam logic PCR_EN_RST = 1'h0;
  // Value returned for a read of an address this block does not own.
  localparam logic [7:0] PCR_UNMAPPED_RD = 8'h00;
endpackage : pcr_pkg

// ===== src/pcr_ch_if.sv
// Write strobes into one compare channel and its stored values back out.
interface pcr_ch_if;
  logic wr_lo; // One-cycle write strobe for the low byte address.
  logic wr_hi; // One-cycle write strobe for the high byte address.
  logic sel; // High when accesses reach the reload value.
  logic [7:0] wdata; // Byte being written.
  logic [15:0] cmp_val; // Stored compare value.
  logic [15:0] rld_val; // Stored reload value.
  logic cmp_en; // Compare function enable.
  modport chan (input wr_lo, input wr_hi, input sel, input wdata,
                output cmp_val, output rld_val, output cmp_en);
  modport ctrl (output wr_lo, output wr_hi, output sel, output wdata,
                input cmp_val, input rld_val, input cmp_en);
endinterface : pcr_ch_if

// ===== src/pcr_channel.sv
// One capture/compare channel: compare value, reload value and enable bit.
module pcr_channel (
  input wire logic core_clk,
  input wire logic rst,
  pcr_ch_if.chan ch
);
  import pcr_pkg::*;

  logic [15:0] cmp_ff; // Compare value.
  logic [15:0] rld_ff; // Auto-reload value for short PWM.
  logic en_ff; // Compare function enable.
  logic [15:0] nxt_cmp;
  logic [15:0] nxt_rld;
  logic nxt_en;

  // Next values: the select bit picks which 16-bit word a byte write lands in.
  always_comb begin
    nxt_cmp = cmp_ff;
    nxt_rld = rld_ff;
    nxt_en = en_ff;
    if (ch.wr_lo) begin
      if (ch.sel) begin
        nxt_rld[7:0] = ch.wdata; // RULE6
      end else begin
        nxt_cmp[7:0] = ch.wdata; // RULE4
      end
      nxt_en = 1'h0; // RULE7
    end
    if (ch.wr_hi) begin
      if (ch.sel) begin
        nxt_rld[15:8] = ch.wdata; // RULE6
      end else begin
        nxt_cmp[15:8] = ch.wdata; // RULE5
      end
      nxt_en = 1'h1; // RULE8
    end
  end

  // Registers, all cleared by reset.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmp_ff <= {PCR_BYTE_RST, PCR_BYTE_RST};
      rld_ff <= {PCR_BYTE_RST, PCR_BYTE_RST};
      en_ff <= PCR_EN_RST;
    end else begin
      cmp_ff <= nxt_cmp;
      rld_ff <= nxt_rld;
      en_ff <= nxt_en;
    end
  end

  assign ch.cmp_val = cmp_ff;
  assign ch.rld_val = rld_ff;
  assign ch.cmp_en = en_ff;
endmodule : pcr_channel

// ===== src/pcr_snapshot.sv
// Live counter high byte and the snapshot that software reads.
module pcr_snapshot (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sw_wr,
  input wire logic lock,
  input wire logic [7:0] wdata,
  input wire logic carry,
  input wire logic low_rd,
  output logic [7:0] hi_live,
  output logic [7:0] hi_snap
);
  import pcr_pkg::*;

  logic [7:0] live_ff; // Bits 15:8 of the counter.
  logic [7:0] snap_ff; // Copy taken when the low byte is read.
  logic [7:0] nxt_live;
  logic [7:0] nxt_snap;

  // A software write beats a carry in the same cycle; the lock drops writes.
  always_comb begin
    nxt_live = live_ff;
    nxt_snap = snap_ff;
    if (sw_wr && !lock) begin
      nxt_live = wdata; // RULE1
    end else if (carry) begin
      nxt_live = live_ff + 8'h01; // RULE1
    end
    if (low_rd) begin
      nxt_snap = live_ff; // RULE2
    end
  end

  // Both bytes clear on reset.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      live_ff <= PCR_BYTE_RST; // RULE1
      snap_ff <= PCR_BYTE_RST;
    end else begin
      live_ff <= nxt_live;
      snap_ff <= nxt_snap;
    end
  end

  assign hi_live = live_ff;
  assign hi_snap = snap_ff;
endmodule : pcr_snapshot

// ===== src/pcr_top.sv
// Register access for the counter array: counter high byte with snapshot,
// and six compare channels reachable over the special function register bus.
module pcr_top #(
  parameter int NUM_CH = pcr_pkg::PCR_NUM_CH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [7:0] counter_low_byte,
  input wire logic counter_carry,
  input wire logic watchdog_lock_enable,
  input wire logic reload_access_select,
  output logic [7:0] counter_high_byte,
  output logic [pcr_pkg::PCR_NUM_CH*16-1:0] compare_value,
  output logic [pcr_pkg::PCR_NUM_CH*16-1:0] reload_value,
  output logic [pcr_pkg::PCR_NUM_CH-1:0] compare_function_enable
);
  import pcr_pkg::*;

  // The address map is fixed at six channels, so no other count is served.
  if (NUM_CH != PCR_NUM_CH) begin : g_bad_count
    $error("pcr_top serves exactly six channels");
  end

  logic [7:0] rdata_ff; // Registered read data.
  logic [7:0] nxt_rdata;
  logic [7:0] hi_snap; // Snapshot byte from the counter module.
  logic [7:0] hi_live; // Live high byte from the counter module.
  logic [PCR_NUM_CH-1:0] lo_hit; // Address matches a compare low byte.
  logic [PCR_NUM_CH-1:0] hi_hit; // Address matches a compare high byte.
  logic [15:0] cmp_w [0:PCR_NUM_CH-1]; // Per-channel compare values.
  logic [15:0] rld_w [0:PCR_NUM_CH-1]; // Per-channel reload values.
  logic cnt_lo_rd; // Software reads the counter low byte.
  logic cnt_hi_wr; // Software writes the counter high byte.

  // Strobes for the counter bytes.
  assign cnt_lo_rd = sfr_rd && (sfr_addr == PCR_CNT_LO_ADDR); // RULE2
  assign cnt_hi_wr = sfr_wr && (sfr_addr == PCR_CNT_HI_ADDR);

  // Live high byte and its snapshot; the lock input guards the write.
  pcr_snapshot u_snap (
    .core_clk(core_clk),
    .rst(rst),
    .sw_wr(cnt_hi_wr),
    .lock(watchdog_lock_enable), // RULE3
    .wdata(sfr_wdata),
    .carry(counter_carry),
    .low_rd(cnt_lo_rd),
    .hi_live(hi_live),
    .hi_snap(hi_snap)
  );

  pcr_ch_if ch_if [0:PCR_NUM_CH-1] ();

  // One channel instance per compare module, with its own address decode.
  for (genvar i = 0; i < PCR_NUM_CH; i++) begin : g_ch
    // Decode the two byte addresses of this channel.
    assign lo_hit[i] = (sfr_addr == PCR_CMP_LO_ADDR[i]);
    assign hi_hit[i] = (sfr_addr == PCR_CMP_HI_ADDR[i]);
    // Drive the channel's write side.
    assign ch_if[i].wr_lo = sfr_wr && lo_hit[i]; // RULE7
    assign ch_if[i].wr_hi = sfr_wr && hi_hit[i]; // RULE8
    assign ch_if[i].sel = reload_access_select; // RULE6
    assign ch_if[i].wdata = sfr_wdata;
    // Bring stored values back for reads and outputs.
    assign cmp_w[i] = ch_if[i].cmp_val;
    assign rld_w[i] = ch_if[i].rld_val;
    assign compare_value[i*16 +: 16] = ch_if[i].cmp_val;
    assign reload_value[i*16 +: 16] = ch_if[i].rld_val;
    // The enable goes out to the comparator of this channel.
    assign compare_function_enable[i] = ch_if[i].cmp_en; // RULE9
    pcr_channel u_ch (
      .core_clk(core_clk),
      .rst(rst),
      .ch(ch_if[i])
    );
  end

  // Read multiplexer; the answer stands from the edge after the read strobe
  // until the next read strobe.
  always_comb begin
    nxt_rdata = rdata_ff;
    if (sfr_rd) begin
      nxt_rdata = PCR_UNMAPPED_RD;
      if (sfr_addr == PCR_CNT_LO_ADDR) begin
        nxt_rdata = counter_low_byte;
      end else if (sfr_addr == PCR_CNT_HI_ADDR) begin
        nxt_rdata = hi_snap; // RULE2
      end else begin
        for (int k = 0; k < PCR_NUM_CH; k++) begin
          if (lo_hit[k]) begin
            nxt_rdata = reload_access_select ? rld_w[k][7:0] : cmp_w[k][7:0]; // RULE6
          end else if (hi_hit[k]) begin
            nxt_rdata = reload_access_select ? rld_w[k][15:8] : cmp_w[k][15:8]; // RULE6
          end
        end
      end
    end
  end

  // Read data register.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= PCR_UNMAPPED_RD;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign sfr_rdata = rdata_ff;
  assign counter_high_byte = hi_live; // RULE1

  // Checks on the register behaviour.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // An unlocked write lands in the live high byte.
  hi_write_take_a: assert property ( // RULE1
    cnt_hi_wr && !watchdog_lock_enable |=> counter_high_byte == $past(sfr_wdata))
    else $error("Unlocked high byte write was not stored.");

  // A locked write without a carry leaves the high byte alone.
  hi_write_lock_a: assert property ( // RULE3
    cnt_hi_wr && watchdog_lock_enable && !counter_carry |=> $stable(counter_high_byte))
    else $error("Locked high byte write changed the counter.");

  // A low read followed by a high read returns the byte live at the low read.
  snap_read_back_a: assert property ( // RULE2
    cnt_lo_rd ##1 (sfr_rd && sfr_addr == PCR_CNT_HI_ADDR)
    |=> sfr_rdata == $past(counter_high_byte, 2))
    else $error("High byte read did not return the snapshot.");

  // Without a low read the snapshot never moves.
  snap_hold_a: assert property ( // RULE2
    !cnt_lo_rd |=> $stable(hi_snap))
    else $error("Snapshot changed without a low byte read.");

  // A low byte write clears that channel's enable.
  lo_clear_en_a: assert property ( // RULE7
    sfr_wr && (lo_hit != '0) |=> (compare_function_enable & $past(lo_hit)) == '0)
    else $error("Low byte write did not clear the enable.");

  // A high byte write sets that channel's enable.
  hi_set_en_a: assert property ( // RULE8
    sfr_wr && (hi_hit != '0) |=> (compare_function_enable & $past(hi_hit)) == $past(hi_hit))
    else $error("High byte write did not set the enable.");

  // Channel zero low byte write with compare selected.
  cmp_lo_store_a: assert property ( // RULE4
    sfr_wr && lo_hit[0] && !reload_access_select
    |=> compare_value[7:0] == $past(sfr_wdata) && $stable(reload_value[15:0]))
    else $error("Compare low byte write was not stored.");

  // Channel zero high byte write with compare selected.
  cmp_hi_store_a: assert property ( // RULE5
    sfr_wr && hi_hit[0] && !reload_access_select
    |=> compare_value[15:8] == $past(sfr_wdata))
    else $error("Compare high byte write was not stored.");

  // With reload selected the compare value is untouched.
  reload_steer_a: assert property ( // RULE6
    sfr_wr && lo_hit[0] && reload_access_select
    |=> reload_value[7:0] == $past(sfr_wdata) && $stable(compare_value[15:0]))
    else $error("Reload select did not steer the write.");

  // The enables change only on compare byte writes.
  en_stable_a: assert property ( // RULE9
    !(sfr_wr && ((lo_hit | hi_hit) != '0)) |=> $stable(compare_function_enable))
    else $error("Compare enable changed without a write.");

  // Main scenarios.
  snap_seq_c: cover property (cnt_lo_rd ##1 (sfr_rd && sfr_addr == PCR_CNT_HI_ADDR));
  lo_then_hi_c: cover property ((sfr_wr && lo_hit[0]) ##1 (sfr_wr && hi_hit[0]));
  locked_wr_c: cover property (cnt_hi_wr && watchdog_lock_enable);
  reload_wr_c: cover property (sfr_wr && hi_hit[5] && reload_access_select);
  wr_carry_c: cover property (cnt_hi_wr && counter_carry);

  // Checks on the read path and on the live counter byte.

  // A low byte read returns the live low byte presented at the read edge.
  lo_read_data_a: assert property ( // RULE2
    cnt_lo_rd |=> sfr_rdata == $past(counter_low_byte))
    else $error("Counter low byte read returned the wrong value.");

  // A high byte read returns the snapshot as it stood at the read edge.
  hi_read_snap_a: assert property ( // RULE2
    sfr_rd && sfr_addr == PCR_CNT_HI_ADDR |=> sfr_rdata == $past(hi_snap))
    else $error("Counter high byte read did not return the snapshot.");

  // A snapshot load takes the live high byte from before the same edge.
  snap_load_a: assert property ( // RULE2
    cnt_lo_rd |=> hi_snap == $past(counter_high_byte))
    else $error("Snapshot did not capture the live high byte.");

  // Read data stand unchanged between read strobes.
  read_hold_a: assert property ( // RULE2
    !sfr_rd |=> $stable(sfr_rdata))
    else $error("Read data changed without a read strobe.");

  // A read of an address this block does not own returns the idle value.
  unmapped_read_a: assert property ( // RULE4
    sfr_rd && sfr_addr != PCR_CNT_LO_ADDR && sfr_addr != PCR_CNT_HI_ADDR
    && (lo_hit | hi_hit) == '0 |=> sfr_rdata == PCR_UNMAPPED_RD)
    else $error("Unmapped read returned a non-idle value.");

  // A carry without an accepted write steps the live high byte by one.
  carry_step_a: assert property ( // RULE1
    counter_carry && !(cnt_hi_wr && !watchdog_lock_enable)
    |=> counter_high_byte == $past(counter_high_byte) + 8'h01)
    else $error("Carry did not step the counter high byte.");

  // Without a carry or an accepted write the live high byte holds.
  hi_hold_a: assert property ( // RULE3
    !counter_carry && !(cnt_hi_wr && !watchdog_lock_enable)
    |=> $stable(counter_high_byte))
    else $error("Counter high byte changed on its own.");

  // Per-channel checks, one copy for each compare module.
  for (genvar j = 0; j < PCR_NUM_CH; j++) begin : g_ch_chk
    // A low byte write with compare selected lands in bits 7:0.
    ch_lo_store_a: assert property ( // RULE4
      sfr_wr && lo_hit[j] && !reload_access_select
      |=> compare_value[j*16 +: 8] == $past(sfr_wdata))
      else $error("Channel compare low byte was not stored.");

    // A high byte write with compare selected lands in bits 15:8.
    ch_hi_store_a: assert property ( // RULE5
      sfr_wr && hi_hit[j] && !reload_access_select
      |=> compare_value[j*16+8 +: 8] == $past(sfr_wdata))
      else $error("Channel compare high byte was not stored.");

    // With reload selected a high byte write reaches the reload word only.
    ch_rld_store_a: assert property ( // RULE6
      sfr_wr && hi_hit[j] && reload_access_select
      |=> reload_value[j*16+8 +: 8] == $past(sfr_wdata)
      && $stable(compare_value[j*16 +: 16]))
      else $error("Channel reload high byte was not steered.");

    // A low byte read returns the word picked by the select at the read edge.
    ch_rd_lo_a: assert property ( // RULE6
      sfr_rd && lo_hit[j]
      |=> sfr_rdata == $past(reload_access_select ? reload_value[j*16 +: 8]
                                                  : compare_value[j*16 +: 8]))
      else $error("Channel low byte read returned the wrong word.");

    // A high byte read returns the word picked by the select at the read edge.
    ch_rd_hi_a: assert property ( // RULE6
      sfr_rd && hi_hit[j]
      |=> sfr_rdata == $past(reload_access_select ? reload_value[j*16+8 +: 8]
                                                  : compare_value[j*16+8 +: 8]))
      else $error("Channel high byte read returned the wrong word.");

    // A low byte write leaves this channel's comparator disabled.
    ch_lo_en_a: assert property ( // RULE7
      sfr_wr && lo_hit[j] |=> !compare_function_enable[j])
      else $error("Channel enable still set after a low byte write.");

    // A high byte write leaves this channel's comparator enabled.
    ch_hi_en_a: assert property ( // RULE8
      sfr_wr && hi_hit[j] |=> compare_function_enable[j])
      else $error("Channel enable still clear after a high byte write.");
  end
endmodule : pcr_top

// ===== verif/counter_compare_register_access_bench.sv
// Self-checking bench for the counter array register access block.
module counter_compare_register_access_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import pcr_pkg::*;

  // Compares a design value with its expectation and counts both outcomes.
  `define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin failures++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

  logic core_clk = 1'b0; // System clock, 25 MHz.
  logic rst = 1'b1; // Asynchronous reset, held at start.
  logic [7:0] sfr_addr = 8'h00; // Register address.
  logic sfr_wr = 1'b0; // Write strobe.
  logic sfr_rd = 1'b0; // Read strobe.
  logic [7:0] sfr_wdata = 8'h00; // Write data.
  logic [7:0] sfr_rdata; // Read data.
  logic [7:0] counter_low_byte = 8'h00; // Live counter low byte.
  logic counter_carry = 1'b0; // Low byte rollover pulse.
  logic watchdog_lock_enable = 1'b0; // Write lock for the high byte.
  logic reload_access_select = 1'b0; // Steers channel bytes to reload values.
  logic [7:0] counter_high_byte; // Live high byte.
  logic [95:0] compare_value; // All compare values.
  logic [95:0] reload_value; // All reload values.
  logic [5:0] compare_function_enable; // Per-channel enables.
  logic [7:0] rd_byte; // Last byte read over the bus.
  logic [7:0] lo; // Expected low byte of the channel under test.
  logic [7:0] hi; // Expected high byte of the channel under test.
  int failures = 0; // Mismatches seen.
  int n_checks = 0; // Comparisons made.
  int cycles = 0; // Clock cycles since time zero.

  // The clock toggles every half period of 20 ns.
  always #20 core_clk = ~core_clk;

  pcr_top pcr_top_inst (
    .core_clk(core_clk),
    .rst(rst),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .counter_low_byte(counter_low_byte),
    .counter_carry(counter_carry),
    .watchdog_lock_enable(watchdog_lock_enable),
    .reload_access_select(reload_access_select),
    .counter_high_byte(counter_high_byte),
    .compare_value(compare_value),
    .reload_value(reload_value),
    .compare_function_enable(compare_function_enable)
  );

  // Prints the verdict and ends the run.
  task automatic final_report();
    if (failures == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  // One write: strobe raised for a single cycle between falling edges.
  task automatic bus_wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge core_clk);
    sfr_addr = addr;
    sfr_wdata = data;
    sfr_wr = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
  endtask : bus_wr

  // One read: read data is settled by the falling edge after the strobe.
  task automatic bus_rd(input logic [7:0] addr, output logic [7:0] data);
    @(negedge core_clk);
    sfr_addr = addr;
    sfr_rd = 1'b1;
    @(negedge core_clk);
    sfr_rd = 1'b0;
    data = sfr_rdata;
  endtask : bus_rd

  // Guards against a hang; the ceiling is far above the expected run.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      final_report();
    end
  end

  // Main sequence of register tests.
  initial begin
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    // Everything comes out of reset cleared.
    `CHK(counter_high_byte, 8'h00)
    `CHK(compare_value, 96'h0)
    `CHK(reload_value, 96'h0)
    `CHK(compare_function_enable, 6'h00)
    `CHK(sfr_rdata, PCR_UNMAPPED_RD)
    bus_wr(PCR_CNT_HI_ADDR, 8'hA5);
    `CHK(counter_high_byte, 8'hA5)
    // A low byte read freezes the high byte copy that software sees.
    counter_low_byte = 8'h3C;
    bus_rd(PCR_CNT_LO_ADDR, rd_byte);
    `CHK(rd_byte, 8'h3C)
    bus_wr(PCR_CNT_HI_ADDR, 8'h5A);
    bus_rd(PCR_CNT_HI_ADDR, rd_byte);
    `CHK(rd_byte, 8'hA5)
    @(negedge core_clk);
    counter_carry = 1'b1;
    @(negedge core_clk);
    counter_carry = 1'b0;
    `CHK(counter_high_byte, 8'h5B)
    bus_rd(PCR_CNT_HI_ADDR, rd_byte);
    `CHK(rd_byte, 8'hA5)
    bus_rd(PCR_CNT_LO_ADDR, rd_byte);
    bus_rd(PCR_CNT_HI_ADDR, rd_byte);
    `CHK(rd_byte, 8'h5B)
    // The watchdog lock blocks writes until it is dropped again.
    watchdog_lock_enable = 1'b1;
    bus_wr(PCR_CNT_HI_ADDR, 8'h77);
    `CHK(counter_high_byte, 8'h5B)
    watchdog_lock_enable = 1'b0;
    bus_wr(PCR_CNT_HI_ADDR, 8'h77);
    `CHK(counter_high_byte, 8'h77)
    // Each channel: low byte first, then high byte, then a lone low write.
    for (int ch = 0; ch < 6; ch++) begin
      lo = 8'h20 + 8'(ch);
      hi = 8'h30 + 8'(ch);
      bus_wr(PCR_CMP_LO_ADDR[ch], lo);
      `CHK(compare_value[ch*16 +: 8], lo)
      `CHK(compare_function_enable[ch], 1'b0)
      bus_wr(PCR_CMP_HI_ADDR[ch], hi);
      `CHK(compare_value[ch*16+8 +: 8], hi)
      `CHK(compare_function_enable[ch], 1'b1)
      bus_rd(PCR_CMP_LO_ADDR[ch], rd_byte);
      `CHK(rd_byte, lo)
      bus_rd(PCR_CMP_HI_ADDR[ch], rd_byte);
      `CHK(rd_byte, hi)
      bus_wr(PCR_CMP_LO_ADDR[ch], ~lo);
      `CHK(compare_function_enable[ch], 1'b0)
      `CHK(compare_value[ch*16 +: 16], {hi, ~lo})
    end
    // With the select high the same addresses reach the reload values.
    reload_access_select = 1'b1;
    for (int ch = 0; ch < 6; ch++) begin
      lo = 8'hC0 + 8'(ch);
      hi = 8'hD0 + 8'(ch);
      bus_wr(PCR_CMP_LO_ADDR[ch], lo);
      bus_wr(PCR_CMP_HI_ADDR[ch], hi);
      `CHK(reload_value[ch*16 +: 16], {hi, lo})
      `CHK(compare_value[ch*16 +: 16], {8'h30 + 8'(ch), ~(8'h20 + 8'(ch))})
      `CHK(compare_function_enable[ch], 1'b1)
      bus_rd(PCR_CMP_HI_ADDR[ch], rd_byte);
      `CHK(rd_byte, hi)
      bus_rd(PCR_CMP_LO_ADDR[ch], rd_byte);
      `CHK(rd_byte, lo)
    end
    reload_access_select = 1'b0;
    bus_rd(PCR_CMP_LO_ADDR[2], rd_byte);
    `CHK(rd_byte, ~8'h22)
    // An address outside the block reads back the fixed idle value.
    bus_rd(8'h00, rd_byte);
    `CHK(rd_byte, PCR_UNMAPPED_RD)
    // Back to back: low read then high read, each answer seen while it stands.
    counter_low_byte = 8'h4E;
    @(negedge core_clk);
    sfr_addr = PCR_CNT_LO_ADDR;
    sfr_rd = 1'b1;
    @(negedge core_clk);
    sfr_addr = PCR_CNT_HI_ADDR;
    `CHK(sfr_rdata, 8'h4E)
    @(negedge core_clk);
    sfr_rd = 1'b0;
    `CHK(sfr_rdata, 8'h77)
    // Back to back: low byte then high byte of channel zero.
    @(negedge core_clk);
    sfr_addr = PCR_CMP_LO_ADDR[0];
    sfr_wdata = 8'h11;
    sfr_wr = 1'b1;
    @(negedge core_clk);
    `CHK(compare_function_enable[0], 1'b0)
    sfr_addr = PCR_CMP_HI_ADDR[0];
    sfr_wdata = 8'h12;
    @(negedge core_clk);
    sfr_wr = 1'b0;
    `CHK(compare_value[15:0], 16'h1211)
    `CHK(compare_function_enable[0], 1'b1)
    `CHK(sfr_rdata, 8'h77)
    // A high byte write and a carry in one cycle: the write wins.
    @(negedge core_clk);
    sfr_addr = PCR_CNT_HI_ADDR;
    sfr_wdata = 8'h10;
    sfr_wr = 1'b1;
    counter_carry = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
    counter_carry = 1'b0;
    `CHK(counter_high_byte, 8'h10)
    // A reset in mid-run clears every register and the read data again.
    @(negedge core_clk);
    rst = 1'b1;
    @(negedge core_clk);
    rst = 1'b0;
    `CHK(counter_high_byte, 8'h00)
    `CHK(compare_value, 96'h0)
    `CHK(reload_value, 96'h0)
    `CHK(compare_function_enable, 6'h00)
    `CHK(sfr_rdata, PCR_UNMAPPED_RD)
    bus_rd(PCR_CNT_HI_ADDR, rd_byte);
    `CHK(rd_byte, 8'h00)
    final_report();
  end
endmodule : counter_compare_register_access_bench
